// file: dv/dpll_phase_model.sv
`timescale 1ns/10ps
module dpll_phase_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] level_i,
    output logic [31:0] phase_error_ns_o
);
    logic [2:0] jit_reg;
    // Wander below level so lock never rides one constant sample
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jit_reg <= 3'h0;
        end else begin
            jit_reg <= jit_reg + 3'h1;
        end
    end
    assign phase_error_ns_o = level_i - {29'h0, jit_reg};
endmodule : dpll_phase_model

// file: dv/synth_cfg_monitor.sv
`timescale 1ns/10ps
module synth_cfg_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [15:0] fec_numerator_o,
    input wire logic [15:0] fec_denominator_o,
    input wire logic synth_enable_o,
    input wire logic [1:0] lock_select_o,
    input wire logic [31:0] center_offset_o,
    input wire logic [31:0] synth_freq_hz_o,
    input wire logic freq_valid_o
);
    logic [7:0] idx;
    logic wr_full;
    assign idx = wb_adr_i[9:2];
    assign wr_full = wb_ack_o && wb_we_i && wb_sel_i == 4'hf;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_SOON: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    AST_DEN_FIELD: assert property (
        wr_full && idx == 8'h54 |=> ##1
        fec_denominator_o == $past(wb_dat_i[15:0], 2))
        else $error("denominator not from low half");
    AST_NUM_FIELD: assert property (
        wr_full && idx == 8'h54 |=> ##1
        fec_numerator_o == $past(wb_dat_i[31:16], 2))
        else $error("numerator not from high half");
    AST_ENABLE: assert property (
        wr_full && idx == 8'h70 |=> ##1
        synth_enable_o == $past(wb_dat_i[0], 2))
        else $error("enable does not follow bit 0");
    AST_LOCK_CODE: assert property (
        wr_full && idx == 8'h72 |=> ##1
        lock_select_o == $past(wb_dat_i[1:0], 2))
        else $error("lock code does not follow write");
    AST_LOCK_RSV: assert property (
        wb_ack_o && !wb_we_i && idx == 8'h72 |->
        wb_dat_o[7:2] == 6'b101010)
        else $error("reserved lock bits changed");
    AST_OFFSET: assert property (
        wr_full && idx == 8'h73 |=> ##1
        center_offset_o == $past(wb_dat_i, 2))
        else $error("offset word not passed whole");
    AST_FREQ_RANGE: assert property (freq_valid_o |->
        synth_freq_hz_o >= 32'd1000000000 &&
        synth_freq_hz_o <= 32'd1500000000)
        else $error("valid flag on out of range result");
    AST_RESET_VAL: assert property (disable iff (1'b0)
        rst_i && $past(rst_i) && $past(rst_i, 2) |->
        lock_select_o == 2'b10 && synth_enable_o &&
        fec_numerator_o == 16'h0001 && fec_denominator_o == 16'h0001)
        else $error("reset values not shown");
endmodule : synth_cfg_monitor

bind synth_frequency_config synth_cfg_monitor i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fec_numerator_o(fec_numerator_o),
    .fec_denominator_o(fec_denominator_o),
    .synth_enable_o(synth_enable_o), .lock_select_o(lock_select_o),
    .center_offset_o(center_offset_o),
    .synth_freq_hz_o(synth_freq_hz_o), .freq_valid_o(freq_valid_o));

// file: dv/test_synth_frequency_config.sv
`timescale 1ns/10ps
module test_synth_frequency_config
    import synth_cfg_pkg::*;
;
    logic clk_i, rst_i, cyc, stb, we, ack, en, valid, locked, irq;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [1:0] lsel;
    logic [15:0] bf, bm, num, den;
    logic [31:0] dw, dr, offs, freq, phase, level;
    int miscompares = 0;
    int num_checks = 0;
    dpll_phase_model i_phase (.clk_i(clk_i), .rst_i(rst_i),
        .level_i(level), .phase_error_ns_o(phase));
    // Short windows keep lock runs brief
    synth_frequency_config #(.LOCK_SHORT_CYC(32'd20),
        .LOCK_LONG_CYC(32'd50)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .phase_error_ns_i(phase), .base_frequency_o(bf),
        .base_multiplier_o(bm), .fec_numerator_o(num),
        .fec_denominator_o(den), .synth_enable_o(en),
        .lock_select_o(lsel), .center_offset_o(offs),
        .synth_freq_hz_o(freq), .freq_valid_o(valid),
        .dpll_locked_o(locked), .irq_o(irq));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] i,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= s;
        dw <= d;
        // Ack and read data are taken only at a rising edge
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check("ack", {31'h0, ack}, 32'h1);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, 4'hf, q);
    endtask : wr
    task automatic rd(input logic [7:0] i, output logic [31:0] q);
        bus(1'b0, i, 32'h0, 4'hf, q);
    endtask : rd
    task automatic wait_done;
        logic [31:0] q;
        int n;
        q = 32'h0;
        for (n = 0; n < 60 && q[1] !== 1'b1; n++) rd(8'h60, q);
        check("calc_done", {31'h0, q[1]}, 32'h1);
    endtask : wait_done
    task automatic t_reset;
        logic [31:0] q;
        rd(8'h54, q);
        check("fec_ratio", q, 32'h00010001);
        rd(8'h72, q);
        check("lock_criterion", q, 32'h000000aa);
        rd(8'h73, q);
        check("offset", q, 32'h046aaaab);
        rd(8'h70, q);
        check("out_en", q, 32'h00000001);
        check("lock_sel_o", {30'h0, lsel}, 32'h2);
        check("base_freq_o", {16'h0, bf}, 32'h61a8);
        check("base_mult_o", {16'h0, bm}, 32'h0ea6);
        wait_done();
        check("freq", freq, 32'd1500000000);
        check("valid", {31'h0, valid}, 32'h1);
        rd(8'h63, q);
        check("calc_status", q, 32'h1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_ratio;
        logic [15:0] n [4] = '{16'd4, 16'd6, 16'd1, 16'd1};
        logic [15:0] d [4] = '{16'd5, 16'd5, 16'd0, 16'd1};
        logic ok [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic [31:0] f, q;
        for (int i = 0; i < 4; i++) begin
            f = (d[i] == 16'd0) ? 32'h0 : 32'd1500000000 / d[i] * n[i];
            wr(8'h60, 32'hf);
            wr(8'h54, {n[i], d[i]});
            wait_done();
            check("num_o", {16'h0, num}, {16'h0, n[i]});
            check("den_o", {16'h0, den}, {16'h0, d[i]});
            check("freq", freq, f);
            check("valid", {31'h0, valid}, {31'h0, ok[i]});
            rd(8'h60, q);
            check("cfg_err", {31'h0, q[0]}, {31'h0, !ok[i]});
        end
        $display("test ratio done");
    endtask : t_ratio
    task automatic t_regs;
        logic [31:0] q;
        wr(8'h70, 32'h0);
        rd(8'h70, q);
        check("out_en", q, 32'h0);
        check("en_o", {31'h0, en}, 32'h0);
        wr(8'h70, 32'hff);
        rd(8'h70, q);
        check("out_en", q, 32'h1);
        check("en_o", {31'h0, en}, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h72, 32'hfc | c);
            rd(8'h72, q);
            check("lock_crit", q, 32'ha8 | c);
            check("lock_sel_o", {30'h0, lsel}, c);
        end
        wr(8'h73, 32'hfffffff0);
        rd(8'h73, q);
        check("offset", q, 32'hfffffff0);
        check("offset_o", offs, 32'hfffffff0);
        bus(1'b1, 8'h54, 32'h0007ffff, 4'b1100, q);
        rd(8'h54, q);
        check("fec_lane", q, 32'h00070001);
        wr(8'h60, 32'hf);
        wait_done();
        check("valid", {31'h0, valid}, 32'h0);
        wr(8'h60, 32'hf);
        wr(8'h54, 32'h00010001);
        wait_done();
        wr(8'h10, 32'hffffffff);
        rd(8'h10, q);
        check("unmapped", q, 32'h0);
        wr(8'h62, 32'h0);
        rd(8'h62, q);
        check("freq_ro", q, 32'd1500000000);
        $display("test registers done");
    endtask : t_regs
    task automatic t_lock;
        logic [1:0] c [6] = '{2'd2, 2'd1, 2'd1, 2'd0, 2'd3, 2'd3};
        logic [31:0] lv [6] = '{32'd5000, 32'd5000, 32'd500, 32'd30000,
                                32'd12000, 32'd9000};
        logic x [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic [31:0] q;
        int n;
        wr(8'h61, 32'h4);
        for (int i = 0; i < 6; i++) begin
            level <= 32'd60000;
            wr(8'h72, {30'h0, c[i]});
            wr(8'h60, 32'hf);
            level <= lv[i];
            n = 0;
            while (locked !== 1'b1 && n < 90) begin
                @(negedge clk_i);
                n++;
            end
            repeat (2) @(negedge clk_i);
            check("locked", {31'h0, locked}, {31'h0, x[i]});
            check("irq", {31'h0, irq}, {31'h0, x[i]});
            @(posedge clk_i);
        end
        wr(8'h60, 32'h4);
        rd(8'h60, q);
        check("irq_clr", {31'h0, irq}, 32'h0);
        wr(8'h61, 32'h0);
        $display("test lock done");
    endtask : t_lock
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we} = 3'h0;
        adr = 10'h0;
        sel = 4'h0;
        dw = 32'h0;
        level = 32'd60000;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_ratio();
        t_regs();
        t_lock();
        stop_test();
    end
endmodule : test_synth_frequency_config

// file: rtl/freq_calc_if.sv
`timescale 1ns/10ps
interface freq_calc_if;
    logic start;
    logic [51:0] dividend;
    logic [15:0] divisor;
    logic busy;
    logic done;
    logic div_zero;
    logic [51:0] quotient;
    modport requester(output start, dividend, divisor,
                      input busy, done, div_zero, quotient);
    modport worker(input start, dividend, divisor,
                   output busy, done, div_zero, quotient);
endinterface : freq_calc_if

// file: rtl/freq_divider.sv
`timescale 1ns/10ps
module freq_divider
    import synth_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    freq_calc_if.worker calc
);
    calc_state_t state_reg;
    logic [5:0] cnt_reg;
    logic [16:0] rem_reg;
    logic [51:0] quot_reg;
    logic zero_reg;
    logic [16:0] trial;

    // Restoring division, one quotient bit a cycle to keep timing easy
    assign trial = {rem_reg[15:0], quot_reg[51]};
    assign calc.busy = (state_reg != CALC_IDLE);
    assign calc.done = (state_reg == CALC_DONE);
    assign calc.div_zero = zero_reg;
    assign calc.quotient = quot_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= CALC_IDLE;
            cnt_reg <= 6'h00;
            rem_reg <= 17'h00000;
            quot_reg <= 52'h0;
            zero_reg <= 1'b0;
        end else begin
            case (state_reg)
                CALC_IDLE: begin
                    if (calc.start) begin
                        zero_reg <= (calc.divisor == 16'h0000);
                        quot_reg <= (calc.divisor == 16'h0000) ?
                                    52'h0 : calc.dividend;
                        rem_reg <= 17'h00000;
                        cnt_reg <= 6'h33;
                        state_reg <= (calc.divisor == 16'h0000) ?
                                     CALC_DONE : CALC_DIV;
                    end
                end
                CALC_DIV: begin
                    if (trial >= {1'b0, calc.divisor}) begin
                        rem_reg <= trial - {1'b0, calc.divisor};
                        quot_reg <= {quot_reg[50:0], 1'b1};
                    end else begin
                        rem_reg <= trial;
                        quot_reg <= {quot_reg[50:0], 1'b0};
                    end
                    if (cnt_reg == 6'h00) begin
                        state_reg <= CALC_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                CALC_DONE: begin
                    state_reg <= CALC_IDLE;
                end
                default: begin
                    state_reg <= CALC_IDLE;
                end
            endcase
        end
    end
endmodule : freq_divider

// file: rtl/lock_qualifier.sv
`timescale 1ns/10ps
`include "synth_cfg_map.svh"
module lock_qualifier
    import synth_cfg_pkg::*;
#(
    parameter logic [31:0] SHORT_CYC = 32'd250000000,
    parameter logic [31:0] LONG_CYC = 32'd2500000000
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] sel_i,
    input wire logic [31:0] phase_error_ns_i,
    output logic locked_o
);
    logic [31:0] limit;
    logic [31:0] window;
    logic [31:0] cnt_reg;
    logic [1:0] sel_reg;

    always_comb begin
        case (lock_sel_t'(sel_i))
            LOCK_36US_10S: begin
                limit = `LOCK_ERR_36US_NS;
                window = LONG_CYC;
            end
            LOCK_1US_1S: begin
                limit = `LOCK_ERR_1US_NS;
                window = SHORT_CYC;
            end
            LOCK_10US_1S: begin
                limit = `LOCK_ERR_10US_NS;
                window = SHORT_CYC;
            end
            default: begin
                limit = `LOCK_ERR_10US_NS;
                window = LONG_CYC;
            end
        endcase
    end

    // A new criterion restarts the window rather than reuse old history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 32'h0;
            locked_o <= 1'b0;
            sel_reg <= 2'h2;
        end else begin
            sel_reg <= sel_i;
            if (sel_reg != sel_i || phase_error_ns_i >= limit) begin
                cnt_reg <= 32'h0;
                locked_o <= 1'b0;
            end else if (cnt_reg >= window - 32'h1) begin
                locked_o <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 32'h1;
            end
        end
    end
endmodule : lock_qualifier

// file: rtl/synth_cfg_map.svh
// Behaviour
// - Frequency is base times multiplier times 16 times ratio
// - Denominator in 15:0, numerator in 31:16
// - Enable bit 0 gates output, resets set
// - Two-bit code picks lock error and window
// - Lock register resets 0xaa, bits 7:2 fixed
// - Offset word signed, steps of 2^-32 nominal
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH
`define IDX_BASE_FREQ 8'h50
`define IDX_BASE_MULT 8'h52
`define IDX_FEC_RATIO 8'h54
`define IDX_IRQ_STATUS 8'h60
`define IDX_IRQ_MASK 8'h61
`define IDX_FREQ_HZ 8'h62
`define IDX_CALC_STATUS 8'h63
`define IDX_OUT_EN 8'h70
`define IDX_LOCK_SEL 8'h72
`define IDX_OFFSET 8'h73
`define RST_BASE_FREQ 16'h61a8
`define RST_BASE_MULT 16'h0ea6
`define RST_FEC_RATIO 32'h00010001
`define RST_OUT_EN 8'h01
`define RST_LOCK_SEL 8'haa
`define RST_OFFSET 32'h046aaaab
`define FEC_DEN_LSB 0
`define FEC_NUM_LSB 16
`define SYNTH_SCALE 52'h10
`define FREQ_MIN_HZ 52'd1000000000
`define FREQ_MAX_HZ 52'd1500000000
`define CLK_HZ 64'd250000000
`define LOCK_SHORT_S 64'd1
`define LOCK_LONG_S 64'd10
`define LOCK_ERR_36US_NS 32'd36000
`define LOCK_ERR_1US_NS 32'd1000
`define LOCK_ERR_10US_NS 32'd10000
`define IRQ_CFG_ERR 0
`define IRQ_CALC_DONE 1
`define IRQ_LOCK_GAIN 2
`define IRQ_LOCK_LOSS 3
`endif

// file: rtl/synth_cfg_pkg.sv
package synth_cfg_pkg;
    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_DIV,
        CALC_DONE
    } calc_state_t;
    typedef enum logic [1:0] {
        LOCK_36US_10S,
        LOCK_1US_1S,
        LOCK_10US_1S,
        LOCK_10US_10S
    } lock_sel_t;
    typedef logic [3:0] irq_vec_t;
endpackage : synth_cfg_pkg

// file: rtl/synth_frequency_config.sv
`timescale 1ns/10ps
`include "synth_cfg_map.svh"
module synth_frequency_config
    import synth_cfg_pkg::*;
#(
    parameter logic [31:0] LOCK_SHORT_CYC =
        32'(`LOCK_SHORT_S * `CLK_HZ),
    parameter logic [31:0] LOCK_LONG_CYC =
        32'(`LOCK_LONG_S * `CLK_HZ)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [31:0] phase_error_ns_i,
    output logic [15:0] base_frequency_o,
    output logic [15:0] base_multiplier_o,
    output logic [15:0] fec_numerator_o,
    output logic [15:0] fec_denominator_o,
    output logic synth_enable_o,
    output logic [1:0] lock_select_o,
    output logic [31:0] center_offset_o,
    output logic [31:0] synth_freq_hz_o,
    output logic freq_valid_o,
    output logic dpll_locked_o,
    output logic irq_o
);
    logic [15:0] base_frequency_reg;
    logic [15:0] base_multiplier_reg;
    logic [31:0] fec_ratio_reg;
    logic [7:0] out_en_reg;
    logic [7:0] lock_criterion_reg;
    logic [31:0] center_offset_reg;
    irq_vec_t irq_status_reg;
    irq_vec_t irq_status_next;
    irq_vec_t irq_mask_reg;
    irq_vec_t irq_event;
    logic [31:0] freq_hz_reg;
    logic freq_valid_reg;
    logic cfg_err_reg;
    logic recalc_reg;
    logic start_reg;
    logic locked_d_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic irq_reg;
    logic req;
    logic wr_fire;
    logic [7:0] word_idx;
    logic [31:0] rd_mux;
    logic locked;
    logic [47:0] prod_bkm;
    logic [51:0] numerator;
    logic in_range;
    logic [31:0] base_freq_merged;
    logic [31:0] base_mult_merged;
    // Reset words typed so their fields can be sliced
    localparam logic [31:0] FEC_RST = `RST_FEC_RATIO;
    localparam logic [7:0] OUT_EN_RST = `RST_OUT_EN;
    localparam logic [7:0] LOCK_RST = `RST_LOCK_SEL;

    freq_calc_if calc ();

    // Word index: printed offsets are indices, byte address is four times
    assign word_idx = wb_adr_i[9:2];
    assign req = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign wr_fire = req & wb_we_i & ack_reg;

    function automatic logic [31:0] merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Lane merge for the 16-bit words; upper lanes are dropped
    always_comb begin
        base_freq_merged = merge({16'h0, base_frequency_reg}, wb_dat_i,
                                 wb_sel_i);
        base_mult_merged = merge({16'h0, base_multiplier_reg}, wb_dat_i,
                                 wb_sel_i);
    end

    // Bus handshake: answer one cycle after the request appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0;
        end else if (req & ~ack_reg & ~wb_we_i) begin
            dat_reg <= rd_mux;
        end
    end

    // Read mux; unmapped words read zero and are still acknowledged
    always_comb begin
        case (word_idx)
            `IDX_BASE_FREQ: rd_mux = {16'h0000, base_frequency_reg};
            `IDX_BASE_MULT: rd_mux = {16'h0000, base_multiplier_reg};
            `IDX_FEC_RATIO: rd_mux = fec_ratio_reg;
            `IDX_IRQ_STATUS: rd_mux = {28'h0, irq_status_reg};
            `IDX_IRQ_MASK: rd_mux = {28'h0, irq_mask_reg};
            `IDX_FREQ_HZ: rd_mux = freq_hz_reg;
            `IDX_CALC_STATUS: begin
                rd_mux = {28'h0, locked_d_reg, calc.busy,
                          cfg_err_reg, freq_valid_reg};
            end
            `IDX_OUT_EN: rd_mux = {24'h0, out_en_reg};
            `IDX_LOCK_SEL: rd_mux = {24'h0, lock_criterion_reg};
            `IDX_OFFSET: rd_mux = center_offset_reg;
            default: rd_mux = 32'h0;
        endcase
    end

    // Synthesizer base settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_frequency_reg <= `RST_BASE_FREQ;
            base_multiplier_reg <= `RST_BASE_MULT;
        end else if (wr_fire) begin
            if (word_idx == `IDX_BASE_FREQ) begin
                base_frequency_reg <= base_freq_merged[15:0];
            end
            if (word_idx == `IDX_BASE_MULT) begin
                base_multiplier_reg <= base_mult_merged[15:0];
            end
        end
    end

    // Ratio word: both halves default to one, i.e. no conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fec_ratio_reg <= `RST_FEC_RATIO;
        end else if (wr_fire && word_idx == `IDX_FEC_RATIO) begin
            fec_ratio_reg <= merge(fec_ratio_reg, wb_dat_i, wb_sel_i);
        end
    end

    // Output enable; only bit 0 is writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_en_reg <= `RST_OUT_EN;
        end else if (wr_fire && word_idx == `IDX_OUT_EN && wb_sel_i[0]) begin
            out_en_reg <= {7'h00, wb_dat_i[0]};
        end
    end

    // Lock criterion; reserved bits keep their default pattern
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_criterion_reg <= `RST_LOCK_SEL;
        end else if (wr_fire && word_idx == `IDX_LOCK_SEL && wb_sel_i[0]) begin
            lock_criterion_reg <= {LOCK_RST[7:2], wb_dat_i[1:0]};
        end
    end

    // Signed centre offset, passed whole to all synthesizers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            center_offset_reg <= `RST_OFFSET;
        end else if (wr_fire && word_idx == `IDX_OFFSET) begin
            center_offset_reg <= merge(center_offset_reg, wb_dat_i,
                                       wb_sel_i);
        end
    end

    // Numerator of the frequency equation, scaled by 16
    assign prod_bkm = base_frequency_reg * base_multiplier_reg
                      * fec_ratio_reg[`FEC_NUM_LSB +: 16];
    assign numerator = {4'h0, prod_bkm} * `SYNTH_SCALE;

    // Recompute after reset and after any change of the equation inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            recalc_reg <= 1'b1;
        end else if (wr_fire && (word_idx == `IDX_BASE_FREQ ||
                                 word_idx == `IDX_BASE_MULT ||
                                 word_idx == `IDX_FEC_RATIO)) begin
            recalc_reg <= 1'b1;
        end else if (start_reg) begin
            recalc_reg <= 1'b0;
        end
    end

    // Launch a division only when idle; a write mid-run queues another
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= recalc_reg & ~start_reg & ~calc.busy;
        end
    end

    assign calc.start = start_reg;
    assign calc.dividend = numerator;
    assign calc.divisor = fec_ratio_reg[`FEC_DEN_LSB +: 16];

    freq_divider u_divider (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .calc(calc)
    );

    // Range check is advisory; the host owns the legal setting
    assign in_range = ~calc.div_zero &&
                      calc.quotient >= `FREQ_MIN_HZ &&
                      calc.quotient <= `FREQ_MAX_HZ;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freq_hz_reg <= 32'h0;
            freq_valid_reg <= 1'b0;
            cfg_err_reg <= 1'b0;
        end else if (calc.done) begin
            freq_hz_reg <= calc.quotient[31:0];
            freq_valid_reg <= in_range;
            cfg_err_reg <= ~in_range;
        end else if (start_reg) begin
            freq_valid_reg <= 1'b0;
        end
    end

    lock_qualifier #(
        .SHORT_CYC(LOCK_SHORT_CYC),
        .LONG_CYC(LOCK_LONG_CYC)
    ) u_lock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_i(lock_criterion_reg[1:0]),
        .phase_error_ns_i(phase_error_ns_i),
        .locked_o(locked)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            locked_d_reg <= 1'b0;
        end else begin
            locked_d_reg <= locked;
        end
    end

    // Interrupt sources
    always_comb begin
        irq_event = '0;
        irq_event[`IRQ_CFG_ERR] = calc.done & ~in_range;
        irq_event[`IRQ_CALC_DONE] = calc.done;
        irq_event[`IRQ_LOCK_GAIN] = locked & ~locked_d_reg;
        irq_event[`IRQ_LOCK_LOSS] = ~locked & locked_d_reg;
    end

    // Write one to clear; a same-cycle event wins over the clear
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_fire && word_idx == `IDX_IRQ_STATUS && wb_sel_i[0]) begin
            irq_status_next = irq_status_reg & ~wb_dat_i[3:0];
        end
        irq_status_next = irq_status_next | irq_event;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_reg <= '0;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    // Mask resets closed so nothing fires before setup
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= '0;
        end else if (wr_fire && word_idx == `IDX_IRQ_MASK && wb_sel_i[0]) begin
            irq_mask_reg <= wb_dat_i[3:0];
        end
    end

    // Registered so the pin cannot glitch on a status update
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // Output stage: every output leaves from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_frequency_o <= `RST_BASE_FREQ;
            base_multiplier_o <= `RST_BASE_MULT;
            fec_numerator_o <= FEC_RST[`FEC_NUM_LSB +: 16];
            fec_denominator_o <= FEC_RST[`FEC_DEN_LSB +: 16];
            synth_enable_o <= OUT_EN_RST[0];
            lock_select_o <= LOCK_RST[1:0];
            center_offset_o <= `RST_OFFSET;
        end else begin
            base_frequency_o <= base_frequency_reg;
            base_multiplier_o <= base_multiplier_reg;
            fec_numerator_o <= fec_ratio_reg[`FEC_NUM_LSB +: 16];
            fec_denominator_o <= fec_ratio_reg[`FEC_DEN_LSB +: 16];
            synth_enable_o <= out_en_reg[0];
            lock_select_o <= lock_criterion_reg[1:0];
            center_offset_o <= center_offset_reg;
        end
    end

    assign synth_freq_hz_o = freq_hz_reg;
    assign freq_valid_o = freq_valid_reg;
    assign dpll_locked_o = locked_d_reg;
    assign irq_o = irq_reg;
    // Ack and read data leave straight from their flops
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
endmodule : synth_frequency_config
